// file: rtl/bdmc_core.sv
// Banked data memory with the core registers seen in every bank.
// Assumes the instruction logic drives file accesses synchronously and
// holds i_reset_n low for power-on and brown-out reset.
`timescale 1ns/100ps
module bdmc_core (
   // Clock and resets
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_other_reset,
   // File access
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [bdmc_pkg::OFF_W-1:0] i_file_addr,
   input wire logic [bdmc_pkg::DATA_W-1:0] i_wr_data,
   output logic [bdmc_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   // Arithmetic result
   input wire logic i_flags_upd,
   input wire logic i_file_clear,
   input wire logic i_sub_op,
   input wire logic i_res_z,
   input wire logic i_res_nibble_carry,
   input wire logic i_res_carry,
   // Reset and sleep logic
   input wire logic i_pwr_flags_we,
   input wire logic i_watchdog_expiry,
   input wire logic i_sleep_entered,
   // Sequencer
   input wire logic i_pc_low_we,
   input wire logic [bdmc_pkg::DATA_W-1:0] i_pc_low_in,
   input wire logic i_acc_we,
   input wire logic [bdmc_pkg::DATA_W-1:0] i_acc_in,
   // Register state
   output logic [bdmc_pkg::DATA_W-1:0] o_pc_low,
   output logic [bdmc_pkg::PCH_W-1:0] o_pc_high_latch,
   output logic [bdmc_pkg::DATA_W-1:0] o_accumulator,
   output logic [bdmc_pkg::BANK_W-1:0] o_bank_selector,
   output logic [bdmc_pkg::DATA_W-1:0] o_irq_control,
   output logic [bdmc_pkg::DATA_W-1:0] o_arith_flags,
   output logic [15:0] o_pointer_zero,
   output logic [15:0] o_pointer_one
);

   // ----------------------------------------------------------------
   // Address resolution
   // ----------------------------------------------------------------
   function automatic bdmc_pkg::bdmc_region_t region_of(
      input logic [6:0] off);
      if (off < bdmc_pkg::SPECIAL_FIRST) begin
         region_of = bdmc_pkg::RG_CORE;
      end else if (off < bdmc_pkg::GENERAL_FIRST) begin
         region_of = bdmc_pkg::RG_SPECIAL;
      end else if (off < bdmc_pkg::COMMON_FIRST) begin
         region_of = bdmc_pkg::RG_GENERAL;
      end else begin
         region_of = bdmc_pkg::RG_COMMON;
      end
   endfunction : region_of

   function automatic logic [11:0] ram_index(input logic [11:0] addr);
      logic [6:0] off;
      off = addr[6:0];
      if (off >= bdmc_pkg::COMMON_FIRST) begin
         ram_index = bdmc_pkg::COMMON_BASE + {8'h00, off[3:0]};
      end else begin
         ram_index = 12'(addr[11:7] * 12'h050)
            + 12'(off - bdmc_pkg::GENERAL_FIRST);
      end
   endfunction : ram_index

   logic [7:0] p0l_r, p0h_r, p1l_r, p1h_r, pcl_r, acc_r, irq_r;
   logic [7:0] p0l_nxt, p0h_nxt, p1l_nxt, p1h_nxt, pcl_nxt, acc_nxt;
   logic [7:0] irq_nxt;
   logic [4:0] bank_r, bank_nxt, flags_r, flags_nxt;
   logic [6:0] pch_r, pch_nxt;

   logic indirect;
   logic [15:0] ptr;
   logic [11:0] eff_addr;
   logic [6:0] eff_off;
   logic eff_ok;
   bdmc_pkg::bdmc_region_t eff_rg;

   // Indirect ports swap in their pointer pair; a pointer that reaches
   // beyond 12 bits or back to an indirect port hits nothing.
   always_comb begin
      indirect = (i_file_addr == bdmc_pkg::OFF_IND0)
         || (i_file_addr == bdmc_pkg::OFF_IND1);
      ptr = (i_file_addr == bdmc_pkg::OFF_IND0) ? {p0h_r, p0l_r}
         : {p1h_r, p1l_r};
      eff_addr = indirect ? ptr[11:0] : {bank_r, i_file_addr};
      eff_off = eff_addr[6:0];
      eff_ok = !indirect || ((ptr[15:12] == bdmc_pkg::PTR_TOP_OK)
         && (eff_off != bdmc_pkg::OFF_IND0)
         && (eff_off != bdmc_pkg::OFF_IND1));
      eff_rg = eff_ok ? region_of(eff_off) : bdmc_pkg::RG_SPECIAL;
   end

   // ----------------------------------------------------------------
   // Core register next state
   // ----------------------------------------------------------------
   logic core_wr;

   always_comb begin
      core_wr = i_wr && (eff_rg == bdmc_pkg::RG_CORE);
      p0l_nxt = p0l_r;
      p0h_nxt = p0h_r;
      p1l_nxt = p1l_r;
      p1h_nxt = p1h_r;
      bank_nxt = bank_r;
      acc_nxt = i_acc_we ? i_acc_in : acc_r;
      pcl_nxt = i_pc_low_we ? i_pc_low_in : pcl_r;
      pch_nxt = pch_r;
      irq_nxt = irq_r;
      flags_nxt = flags_r;
      if (core_wr) begin
         case (eff_off)
            bdmc_pkg::OFF_PCL: pcl_nxt = i_wr_data;
            bdmc_pkg::OFF_P0L: p0l_nxt = i_wr_data;
            bdmc_pkg::OFF_P0H: p0h_nxt = i_wr_data;
            bdmc_pkg::OFF_P1L: p1l_nxt = i_wr_data;
            bdmc_pkg::OFF_P1H: p1h_nxt = i_wr_data;
            bdmc_pkg::OFF_BANK: bank_nxt = i_wr_data[4:0];
            bdmc_pkg::OFF_ACC: acc_nxt = i_wr_data;
            bdmc_pkg::OFF_PCH: pch_nxt = i_wr_data[6:0];
            bdmc_pkg::OFF_IRQ: irq_nxt = i_wr_data;
            bdmc_pkg::OFF_FLAGS: begin
               // Only the three result flags take a file write, and only while i_flags_upd is low.
               if (!i_flags_upd) begin
                  flags_nxt[2:0] = i_wr_data[2:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (i_flags_upd) begin
         flags_nxt[bdmc_pkg::FL_Z] = i_file_clear || i_res_z;
         if (!i_file_clear) begin
            flags_nxt[bdmc_pkg::FL_DC] = i_res_nibble_carry ^ i_sub_op;
            flags_nxt[bdmc_pkg::FL_C] = i_res_carry ^ i_sub_op;
         end
      end
      if (i_pwr_flags_we) begin
         flags_nxt[bdmc_pkg::FL_TO] = i_watchdog_expiry;
         flags_nxt[bdmc_pkg::FL_PD] = i_sleep_entered;
      end
      if (i_other_reset) begin
         p0h_nxt = bdmc_pkg::BYTE_RST;
         p1h_nxt = bdmc_pkg::BYTE_RST;
         pcl_nxt = bdmc_pkg::BYTE_RST;
         bank_nxt = bdmc_pkg::BANK_RST;
         pch_nxt = bdmc_pkg::PCH_RST;
         irq_nxt = {7'h00, irq_r[bdmc_pkg::IRQ_KEEP_BIT]};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         p0l_r <= bdmc_pkg::BYTE_RST;
         p0h_r <= bdmc_pkg::BYTE_RST;
         p1l_r <= bdmc_pkg::BYTE_RST;
         p1h_r <= bdmc_pkg::BYTE_RST;
         pcl_r <= bdmc_pkg::BYTE_RST;
         acc_r <= bdmc_pkg::BYTE_RST;
         irq_r <= bdmc_pkg::BYTE_RST;
         bank_r <= bdmc_pkg::BANK_RST;
         pch_r <= bdmc_pkg::PCH_RST;
         flags_r <= bdmc_pkg::FLAGS_RST;
      end else begin
         p0l_r <= p0l_nxt;
         p0h_r <= p0h_nxt;
         p1l_r <= p1l_nxt;
         p1h_r <= p1h_nxt;
         pcl_r <= pcl_nxt;
         acc_r <= acc_nxt;
         irq_r <= irq_nxt;
         bank_r <= bank_nxt;
         pch_r <= pch_nxt;
         flags_r <= flags_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] core_q_r, core_q_nxt;
   bdmc_pkg::bdmc_region_t src_r, src_nxt;
   logic valid_r, valid_nxt;
   logic [7:0] ram_q;
   logic ram_sel;

   always_comb begin
      ram_sel = (eff_rg == bdmc_pkg::RG_GENERAL)
         || (eff_rg == bdmc_pkg::RG_COMMON);
      valid_nxt = i_rd;
      src_nxt = i_rd ? eff_rg : src_r;
      core_q_nxt = core_q_r;
      if (i_rd) begin
         case (eff_off)
            bdmc_pkg::OFF_PCL: core_q_nxt = pcl_r;
            bdmc_pkg::OFF_FLAGS: core_q_nxt = {3'h0, flags_r};
            bdmc_pkg::OFF_P0L: core_q_nxt = p0l_r;
            bdmc_pkg::OFF_P0H: core_q_nxt = p0h_r;
            bdmc_pkg::OFF_P1L: core_q_nxt = p1l_r;
            bdmc_pkg::OFF_P1H: core_q_nxt = p1h_r;
            bdmc_pkg::OFF_BANK: core_q_nxt = {3'h0, bank_r};
            bdmc_pkg::OFF_ACC: core_q_nxt = acc_r;
            bdmc_pkg::OFF_PCH: core_q_nxt = {1'b0, pch_r};
            bdmc_pkg::OFF_IRQ: core_q_nxt = irq_r;
            default: core_q_nxt = bdmc_pkg::BYTE_RST;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         core_q_r <= bdmc_pkg::BYTE_RST;
         src_r <= bdmc_pkg::RG_SPECIAL;
         valid_r <= 1'b0;
      end else begin
         core_q_r <= core_q_nxt;
         src_r <= src_nxt;
         valid_r <= valid_nxt;
      end
   end

   bdmc_ram u_ram (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_wr(i_wr && ram_sel),
      .i_wr_addr(ram_index(eff_addr)),
      .i_wr_data(i_wr_data),
      .i_rd(i_rd && ram_sel),
      .i_rd_addr(ram_index(eff_addr)),
      .o_rd_data(ram_q)
   );

   always_comb begin
      case (src_r)
         bdmc_pkg::RG_CORE: o_rd_data = core_q_r;
         bdmc_pkg::RG_GENERAL: o_rd_data = ram_q;
         bdmc_pkg::RG_COMMON: o_rd_data = ram_q;
         default: o_rd_data = bdmc_pkg::BYTE_RST;
      endcase
   end

   assign o_rd_valid = valid_r;
   assign o_pc_low = pcl_r;
   assign o_pc_high_latch = pch_r;
   assign o_accumulator = acc_r;
   assign o_bank_selector = bank_r;
   assign o_irq_control = irq_r;
   assign o_arith_flags = {3'h0, flags_r};
   assign o_pointer_zero = {p0h_r, p0l_r};
   assign o_pointer_one = {p1h_r, p1l_r};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_direct_ram_write;
      i_wr && !i_rd && !i_other_reset && (i_file_addr == 7'h25);
   endsequence

   sequence s_pointer_read_same;
      i_rd && (i_file_addr == bdmc_pkg::OFF_IND0)
         && (o_pointer_zero == {4'h0, o_bank_selector, 7'h25});
   endsequence

   a_bank_follows_write: assert property (
      i_wr && !i_other_reset && (i_file_addr == bdmc_pkg::OFF_BANK)
      |=> o_bank_selector == $past(i_wr_data[4:0]))
      else $error("bank selector did not take written value");

   a_special_reads_zero: assert property (
      i_rd && (i_file_addr >= bdmc_pkg::SPECIAL_FIRST)
      && (i_file_addr < bdmc_pkg::GENERAL_FIRST)
      |=> o_rd_valid && (o_rd_data == 8'h00))
      else $error("unimplemented location read nonzero");

   a_acc_any_bank: assert property (
      i_rd && (i_file_addr == bdmc_pkg::OFF_ACC)
      |=> o_rd_data == $past(o_accumulator))
      else $error("accumulator not visible in selected bank");

   a_ram_via_pointer: assert property (
      (s_direct_ram_write ##1 !i_wr ##1 (s_pointer_read_same and !i_wr))
      |=> o_rd_data == $past(i_wr_data, 3))
      else $error("pointer read missed direct write");

   a_flags_write_blocked: assert property (
      core_wr && (eff_off == bdmc_pkg::OFF_FLAGS) && i_flags_upd
      && !i_file_clear
      |=> o_arith_flags[bdmc_pkg::FL_Z] == $past(i_res_z))
      else $error("flag write overrode result flag");

   a_power_flags_hold: assert property (
      core_wr && !i_pwr_flags_we
      |=> $stable(o_arith_flags[4:3]))
      else $error("instruction write changed power flags");

   a_clear_sets_zero: assert property (
      i_flags_upd && i_file_clear && !i_pwr_flags_we
      |=> o_arith_flags[bdmc_pkg::FL_Z]
         && (o_arith_flags[1:0] == $past(o_arith_flags[1:0])))
      else $error("file clear did not set zero and keep carries");

   a_sub_inverts_borrow: assert property (
      i_flags_upd && !i_file_clear && i_sub_op
      |=> o_arith_flags[bdmc_pkg::FL_C] == !$past(i_res_carry))
      else $error("subtract carry is not inverted borrow");

   a_other_reset_keeps: assert property (
      i_other_reset && !i_acc_we && !i_wr
      |=> $stable(o_accumulator) && (o_bank_selector == 5'h00)
         && (o_pointer_zero[15:8] == 8'h00))
      else $error("other reset handled registers wrongly");

endmodule : bdmc_core

// file: rtl/bdmc_pkg.sv
// Constants and types for the banked data memory and its core registers.
// Assumes every user refers to these names through the package scope.
package bdmc_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 5;
   localparam int OFF_W = 7;
   localparam int NUM_BANKS = 32;
   localparam int BANK_BYTES = 128;
   localparam int CORE_REGS = 12;
   localparam int SPECIAL_REGS = 20;
   localparam int GENERAL_BYTES = 80;
   localparam int COMMON_BYTES = 16;
   localparam int RAM_DEPTH = NUM_BANKS * GENERAL_BYTES + COMMON_BYTES;
   localparam int RAM_AW = 12;
   localparam logic [RAM_AW-1:0] COMMON_BASE = 12'hA00;

   // ----------------------------------------------------------------
   // Offsets inside every bank
   // ----------------------------------------------------------------
   localparam logic [6:0] OFF_IND0 = 7'h00;
   localparam logic [6:0] OFF_IND1 = 7'h01;
   localparam logic [6:0] OFF_PCL = 7'h02;
   localparam logic [6:0] OFF_FLAGS = 7'h03;
   localparam logic [6:0] OFF_P0L = 7'h04;
   localparam logic [6:0] OFF_P0H = 7'h05;
   localparam logic [6:0] OFF_P1L = 7'h06;
   localparam logic [6:0] OFF_P1H = 7'h07;
   localparam logic [6:0] OFF_BANK = 7'h08;
   localparam logic [6:0] OFF_ACC = 7'h09;
   localparam logic [6:0] OFF_PCH = 7'h0A;
   localparam logic [6:0] OFF_IRQ = 7'h0B;
   localparam logic [6:0] SPECIAL_FIRST = 7'h0C;
   localparam logic [6:0] GENERAL_FIRST = 7'h20;
   localparam logic [6:0] COMMON_FIRST = 7'h70;

   // ----------------------------------------------------------------
   // Flag register fields and reset values
   // ----------------------------------------------------------------
   localparam int FL_W = 5;
   localparam int FL_TO = 4;
   localparam int FL_PD = 3;
   localparam int FL_Z = 2;
   localparam int FL_DC = 1;
   localparam int FL_C = 0;
   localparam logic [4:0] FLAGS_RST = 5'h18;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [4:0] BANK_RST = 5'h00;
   localparam int PCH_W = 7;
   localparam logic [6:0] PCH_RST = 7'h00;
   localparam int IRQ_KEEP_BIT = 0;
   localparam logic [3:0] PTR_TOP_OK = 4'h0;

   typedef enum logic [1:0] {
      RG_CORE = 2'b00,
      RG_SPECIAL = 2'b01,
      RG_GENERAL = 2'b10,
      RG_COMMON = 2'b11
   } bdmc_region_t;

endpackage : bdmc_pkg

// file: rtl/bdmc_ram.sv
// Storage for general RAM of all banks plus the shared bytes.
// Assumes one clock; read data appear one edge after the read request.
`timescale 1ns/100ps
module bdmc_ram (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Write side
   input wire logic i_wr,
   input wire logic [bdmc_pkg::RAM_AW-1:0] i_wr_addr,
   input wire logic [bdmc_pkg::DATA_W-1:0] i_wr_data,
   // Read side
   input wire logic i_rd,
   input wire logic [bdmc_pkg::RAM_AW-1:0] i_rd_addr,
   output logic [bdmc_pkg::DATA_W-1:0] o_rd_data
);

   logic [bdmc_pkg::DATA_W-1:0] mem_r [bdmc_pkg::RAM_DEPTH];
   logic [bdmc_pkg::DATA_W-1:0] q_r;
   logic [bdmc_pkg::DATA_W-1:0] q_nxt;

   // A read of a word written in the same cycle returns the old contents.
   always_comb begin
      q_nxt = q_r;
      if (i_rd) begin
         q_nxt = mem_r[i_rd_addr];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         q_r <= bdmc_pkg::BYTE_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_wr) begin
         mem_r[i_wr_addr] <= i_wr_data;
      end
   end

   assign o_rd_data = q_r;

endmodule : bdmc_ram

// file: testbench/bdmc_core_model.sv
// Behavioural model of the instruction logic that drives the file bus.
// Assumes one caller at a time; requests change just after a falling
// edge and are held across the rising edge that takes them.
`timescale 1ns/100ps
module bdmc_core_model (
   // Clock
   input wire logic i_ref_clk,
   // File bus towards the design
   output logic o_rd,
   output logic o_wr,
   output logic [6:0] o_addr,
   output logic [7:0] o_data,
   // Answer from the design
   input wire logic i_rd_valid,
   input wire logic [7:0] i_rd_data
);
   // ---------------------------------------------------------------
   // File bus cycles
   // ---------------------------------------------------------------
   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 7'h55;
      o_data = 8'hAA;
   end

   // A released bus shows the inverse of its last address and last write data, so a design
   // that samples it outside a request cannot pass by luck.
   // The flag register is only written by plain moves from here.
   task automatic file_wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_data = d;
      @(negedge i_ref_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_data = ~d;
   endtask : file_wr

   task automatic file_rd(input logic [6:0] a, output logic v,
      output logic [7:0] d);
      @(negedge i_ref_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_ref_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      v = i_rd_valid;
      d = i_rd_data;
   endtask : file_rd
endmodule : bdmc_core_model

// file: testbench/testbench.sv
// Self-checking bench for the banked data memory core.
// Assumes the design answers reads at the rising edge that takes them, half a cycle before the model samples.
`timescale 1ns/100ps
module testbench;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic i_ref_clk;
   logic i_reset_n;
   logic i_other_reset;
   logic rd, wr, rd_valid;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   logic upd, fclr, sub, rz, rdc, rc, pwe, wdx, slp, pcwe, accwe;
   logic [7:0] pc_in, acc_in, pc_lo, acc, irq, flags;
   logic [6:0] pch;
   logic [4:0] bank;
   logic [15:0] p0, p1;
   logic [79:0] st;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [6:0] t_off [10] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h07,
      7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C};
   logic [7:0] t_wr [10] = '{8'hA5, 8'h3C, 8'h00, 8'h11, 8'h01,
      8'hFF, 8'h5A, 8'hFF, 8'hFF, 8'h77};
   logic [7:0] t_exp [10] = '{8'hA5, 8'h3C, 8'h00, 8'h11, 8'h01,
      8'h1F, 8'h5A, 8'h7F, 8'hFF, 8'h00};

   assign st = {pc_lo, 1'b0, pch, acc, 3'h0, bank, irq, flags, p0, p1};

   always #20 i_ref_clk = ~i_ref_clk;

   // ---------------------------------------------------------------
   // Design and partner
   // ---------------------------------------------------------------
   bdmc_core dut_u (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_other_reset(i_other_reset),
      .i_rd(rd),
      .i_wr(wr),
      .i_file_addr(addr),
      .i_wr_data(wdata),
      .o_rd_data(rdata),
      .o_rd_valid(rd_valid),
      .i_flags_upd(upd),
      .i_file_clear(fclr),
      .i_sub_op(sub),
      .i_res_z(rz),
      .i_res_nibble_carry(rdc),
      .i_res_carry(rc),
      .i_pwr_flags_we(pwe),
      .i_watchdog_expiry(wdx),
      .i_sleep_entered(slp),
      .i_pc_low_we(pcwe),
      .i_pc_low_in(pc_in),
      .i_acc_we(accwe),
      .i_acc_in(acc_in),
      .o_pc_low(pc_lo),
      .o_pc_high_latch(pch),
      .o_accumulator(acc),
      .o_bank_selector(bank),
      .o_irq_control(irq),
      .o_arith_flags(flags),
      .o_pointer_zero(p0),
      .o_pointer_one(p1)
   );

   bdmc_core_model core_u (
      .i_ref_clk(i_ref_clk),
      .o_rd(rd),
      .o_wr(wr),
      .o_addr(addr),
      .o_data(wdata),
      .i_rd_valid(rd_valid),
      .i_rd_data(rdata)
   );

   // ---------------------------------------------------------------
   // Checking tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [79:0] seen,
      input logic [79:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic fw(input logic [6:0] a, input logic [7:0] d);
      core_u.file_wr(a, d);
   endtask : fw

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      logic v;
      logic [7:0] d;
      core_u.file_rd(a, v, d);
      chk("rd_valid", {79'h0, v}, {79'h0, 1'b1});
      chk("rd_data", {72'h0, d}, {72'h0, e});
   endtask : rd_chk

   task automatic alu(input logic [5:0] s);
      @(negedge i_ref_clk);
      {upd, fclr, sub, rz, rdc, rc} = s;
   endtask : alu

   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   // The tests take about 140 cycles; the limit allows over fourteen times that.
   initial begin
      #80000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      i_ref_clk = 1'b0;
      i_reset_n = 1'b0;
      i_other_reset = 1'b0;
      {upd, fclr, sub, rz, rdc, rc} = 6'h00;
      {pwe, wdx, slp, pcwe, accwe} = 5'h00;
      pc_in = 8'h00;
      acc_in = 8'h00;
      repeat (3) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      @(negedge i_ref_clk);
      chk("reset state", st, {40'h0, 8'h18, 32'h0});
      rd_chk(7'h03, 8'h18);
      for (int k = 0; k < 10; k++) begin
         fw(t_off[k], t_wr[k]);
         rd_chk(t_off[k], t_exp[k]);
      end
      fw(7'h03, 8'hE7);
      rd_chk(7'h03, 8'h1F);
      chk("core ports", st, {8'hA5, 8'h7F, 8'h5A, 8'h1F, 8'hFF, 8'h1F,
         16'h003C, 16'h0111});
      @(negedge i_ref_clk);
      i_other_reset = 1'b1;
      @(negedge i_ref_clk);
      i_other_reset = 1'b0;
      chk("other reset", st, {8'h00, 8'h00, 8'h5A, 8'h00, 8'h01, 8'h1F,
         16'h003C, 16'h0011});
      // Same offset in two banks, then the top general byte of bank 31.
      fw(7'h20, 8'hA1);
      fw(7'h08, 8'h01);
      fw(7'h20, 8'hB2);
      rd_chk(7'h20, 8'hB2);
      fw(7'h08, 8'h00);
      rd_chk(7'h20, 8'hA1);
      fw(7'h08, 8'h1F);
      fw(7'h6F, 8'hC3);
      rd_chk(7'h6F, 8'hC3);
      fw(7'h70, 8'hD4);
      fw(7'h08, 8'h02);
      rd_chk(7'h70, 8'hD4);
      // Indirect ports through both pointer pairs.
      fw(7'h04, 8'hA0);
      fw(7'h05, 8'h00);
      rd_chk(7'h00, 8'hB2);
      fw(7'h06, 8'hEF);
      fw(7'h07, 8'h0F);
      rd_chk(7'h01, 8'hC3);
      fw(7'h01, 8'h99);
      fw(7'h08, 8'h1F);
      rd_chk(7'h6F, 8'h99);
      fw(7'h04, 8'h09);
      rd_chk(7'h00, 8'h5A);
      fw(7'h04, 8'h8C);
      fw(7'h05, 8'h02);
      rd_chk(7'h00, 8'h00);
      fw(7'h05, 8'h10);
      rd_chk(7'h00, 8'h00);
      fw(7'h08, 8'h03);
      fw(7'h04, 8'hA5);
      fw(7'h05, 8'h01);
      fw(7'h25, 8'h6B);
      rd_chk(7'h00, 8'h6B);
      // Arithmetic flags against instruction writes.
      alu(6'b100101);
      fw(7'h03, 8'h02);
      alu(6'b000000);
      chk("flags", {72'h0, flags}, {72'h0, 8'h1D});
      alu(6'b101001);
      alu(6'b000000);
      chk("flags", {72'h0, flags}, {72'h0, 8'h1A});
      fw(7'h03, 8'h00);
      alu(6'b110011);
      fw(7'h03, 8'h00);
      alu(6'b000000);
      chk("flags", {72'h0, flags}, {72'h0, 8'h1C});
      {pwe, wdx, slp} = 3'b101;
      @(negedge i_ref_clk);
      pwe = 1'b0;
      chk("flags", {72'h0, flags}, {72'h0, 8'h0C});
      // Sequencer loads, and a file write winning over a load.
      {accwe, acc_in, pcwe, pc_in} = {1'b1, 8'h3E, 1'b1, 8'h81};
      @(negedge i_ref_clk);
      {accwe, pcwe} = 2'b00;
      chk("acc pc", {64'h0, acc, pc_lo}, {64'h0, 8'h3E, 8'h81});
      accwe = 1'b1;
      acc_in = 8'h44;
      fw(7'h09, 8'h55);
      accwe = 1'b0;
      chk("acc", {72'h0, acc}, {72'h0, 8'h55});
      // Power-on reset again in mid-run.
      i_reset_n = 1'b0;
      repeat (3) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      @(negedge i_ref_clk);
      chk("reset state", st, {40'h0, 8'h18, 32'h0});
      give_verdict();
   end
endmodule : testbench
